/* File: rtl/jtag_map.vh */
// Behaviour
// - ten-bit instruction register shifts in instruction states
// - user signature register is thirty-two bits, shifted out
// - boundary chain length fixed per device variant
// - identity word: version, part, maker, trailing bit
// - identity word bit zero always reads one
// - leftmost identity bit is bit thirty-one
// - pull-up, or bus hold where pull-up is off, overrides tri-state
// - bypass, highz, clamp select one-bit bypass register
// - identity instruction shifts identity register out
// - clamp holds pins at boundary update values
//
`ifndef JTAG_MAP_VH
`define JTAG_MAP_VH

// =====================================================
// register lengths
`define IR_LEN          10
`define USER_LEN        32
`define ID_LEN          32
`define BSR_LEN_V0      1029
`define BSR_LEN_V1      1665
`define BSR_LEN_V2      1941
`define PIN_COUNT       8

// =====================================================
// identity word field positions
`define ID_VER_MSB      31
`define ID_VER_LSB      28
`define ID_PART_MSB     27
`define ID_PART_LSB     12
`define ID_MANUF_MSB    11
`define ID_MANUF_LSB    1
`define ID_MARK_BIT     0

// =====================================================
// reset and capture values
`define IR_CAPTURE      10'h001
`define BYPASS_CAPTURE  1'b0

// =====================================================
// instruction codes
`define INS_EXTEST      10'h000
`define INS_SAMPLE      10'h005
`define INS_IDENT       10'h006
`define INS_USER        10'h007
`define INS_CLAMP       10'h00A
`define INS_HIGHZ       10'h00B
`define INS_BYPASS      10'h3FF

`endif

/* File: rtl/boundary_scan_chain.v */
`timescale 1ns/1ps
`default_nettype none

module boundary_scan_chain #(
  parameter LEN  = 1029,
  parameter PINS = 8
) (
  input  wire            clk_sys,
  input  wire            sys_rst,
  input  wire            cap_en,
  input  wire            shift_en,
  input  wire            upd_en,
  input  wire            scan_in,
  input  wire [PINS-1:0] pin_in,
  input  wire [PINS-1:0] pin_out,
  input  wire [PINS-1:0] pin_oe,
  output wire            scan_lsb,
  output reg  [PINS-1:0] upd_out_reg,
  output reg  [PINS-1:0] upd_oe_reg
);

  reg  [LEN-1:0] chain_reg;
  wire [LEN-1:0] cap_vec;

  assign scan_lsb = chain_reg[0];

  // =====================================================
  // capture map: three cells per pin, rest are internal cells
  genvar i;
  generate
    for (i = 0; i < LEN; i = i + 1) begin : g_cell
      if (i < 3 * PINS) begin : g_pin
        if (i % 3 == 0) begin : g_in
          assign cap_vec[i] = pin_in[i/3];
        end else if (i % 3 == 1) begin : g_out
          assign cap_vec[i] = pin_out[i/3];
        end else begin : g_oe
          assign cap_vec[i] = pin_oe[i/3];
        end
      end else begin : g_int
        assign cap_vec[i] = 1'b0;
      end
    end
  endgenerate

  // =====================================================
  // shift stage, lsb toward tdo
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      chain_reg <= {LEN{1'b0}};
    end else if (cap_en) begin
      chain_reg <= cap_vec;
    end else if (shift_en) begin
      chain_reg <= {scan_in, chain_reg[LEN-1:1]};
    end
  end

  // =====================================================
  // update stage, holds pin values for extest and clamp
  genvar p;
  generate
    for (p = 0; p < PINS; p = p + 1) begin : g_upd
      always @(posedge clk_sys) begin
        if (sys_rst) begin
          upd_out_reg[p] <= 1'b0;
          upd_oe_reg[p]  <= 1'b0;
        end else if (upd_en) begin
          upd_out_reg[p] <= chain_reg[3*p+1];
          upd_oe_reg[p]  <= chain_reg[3*p+2];
        end
      end
    end
  endgenerate

endmodule

`default_nettype wire

/* File: rtl/jtag_scan_identity_registers.v */
`timescale 1ns/1ps
`default_nettype none
`include "jtag_map.vh"

module jtag_scan_identity_registers #(
  parameter        VARIANT    = 0,
  parameter [3:0]  ID_VERSION = 4'h3,   // arbitrary value
  parameter [15:0] ID_PART    = 16'hA5C3, // arbitrary value
  parameter [10:0] ID_MANUF   = 11'h2B5  // arbitrary value
) (
  input  wire        clk_sys,
  input  wire        sys_rst,
  input  wire        tck,
  input  wire        tms,
  input  wire        tdi,
  output reg         tdo_reg,
  output reg         tdo_oe_reg,
  input  wire [31:0] user_code,
  input  wire [7:0]  core_out,
  input  wire [7:0]  core_oe,
  output reg  [7:0]  core_in_reg,
  input  wire [7:0]  pad_in,
  input  wire [7:0]  pull_up_en,
  input  wire [7:0]  bus_hold_en,
  output reg  [7:0]  pad_out_reg,
  output reg  [7:0]  pad_oe_reg,
  output reg  [7:0]  pad_pull_reg,
  output reg  [7:0]  pad_hold_reg
);

  localparam BSR_LEN = (VARIANT == 2) ? `BSR_LEN_V2 :
                       (VARIANT == 1) ? `BSR_LEN_V1 : `BSR_LEN_V0;

  localparam [3:0] ST_RESET  = 4'h0;
  localparam [3:0] ST_IDLE   = 4'h1;
  localparam [3:0] ST_SEL_DR = 4'h2;
  localparam [3:0] ST_CAP_DR = 4'h3;
  localparam [3:0] ST_SH_DR  = 4'h4;
  localparam [3:0] ST_EX1_DR = 4'h5;
  localparam [3:0] ST_PA_DR  = 4'h6;
  localparam [3:0] ST_EX2_DR = 4'h7;
  localparam [3:0] ST_UPD_DR = 4'h8;
  localparam [3:0] ST_SEL_IR = 4'h9;
  localparam [3:0] ST_CAP_IR = 4'hA;
  localparam [3:0] ST_SH_IR  = 4'hB;
  localparam [3:0] ST_EX1_IR = 4'hC;
  localparam [3:0] ST_PA_IR  = 4'hD;
  localparam [3:0] ST_EX2_IR = 4'hE;
  localparam [3:0] ST_UPD_IR = 4'hF;

  // =====================================================
  // pin synchronisers
  reg        tck_s1_reg;
  reg        tck_s2_reg;
  reg        tck_d_reg;
  reg        tms_s1_reg;
  reg        tms_s2_reg;
  reg        tdi_s1_reg;
  reg        tdi_s2_reg;
  reg  [7:0] pad_s1_reg;
  reg  [7:0] pad_s2_reg;

  always @(posedge clk_sys) begin
    if (sys_rst) begin
      tck_s1_reg <= 1'b0;
      tck_s2_reg <= 1'b0;
      tck_d_reg  <= 1'b0;
      tms_s1_reg <= 1'b1;
      tms_s2_reg <= 1'b1;
      tdi_s1_reg <= 1'b0;
      tdi_s2_reg <= 1'b0;
      pad_s1_reg <= 8'h00;
      pad_s2_reg <= 8'h00;
    end else begin
      tck_s1_reg <= tck;
      tck_s2_reg <= tck_s1_reg;
      tck_d_reg  <= tck_s2_reg;
      tms_s1_reg <= tms;
      tms_s2_reg <= tms_s1_reg;
      tdi_s1_reg <= tdi;
      tdi_s2_reg <= tdi_s1_reg;
      pad_s1_reg <= pad_in;
      pad_s2_reg <= pad_s1_reg;
    end
  end

  wire tck_rise = tck_s2_reg & ~tck_d_reg;
  wire tck_fall = ~tck_s2_reg & tck_d_reg;

  // =====================================================
  // tap state machine
  reg [3:0] state_reg;
  reg [3:0] state_next;

  always @* begin
    case (state_reg)
      ST_RESET:  state_next = tms_s2_reg ? ST_RESET  : ST_IDLE;
      ST_IDLE:   state_next = tms_s2_reg ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR: state_next = tms_s2_reg ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: state_next = tms_s2_reg ? ST_EX1_DR : ST_SH_DR;
      ST_SH_DR:  state_next = tms_s2_reg ? ST_EX1_DR : ST_SH_DR;
      ST_EX1_DR: state_next = tms_s2_reg ? ST_UPD_DR : ST_PA_DR;
      ST_PA_DR:  state_next = tms_s2_reg ? ST_EX2_DR : ST_PA_DR;
      ST_EX2_DR: state_next = tms_s2_reg ? ST_UPD_DR : ST_SH_DR;
      ST_UPD_DR: state_next = tms_s2_reg ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR: state_next = tms_s2_reg ? ST_RESET  : ST_CAP_IR;
      ST_CAP_IR: state_next = tms_s2_reg ? ST_EX1_IR : ST_SH_IR;
      ST_SH_IR:  state_next = tms_s2_reg ? ST_EX1_IR : ST_SH_IR;
      ST_EX1_IR: state_next = tms_s2_reg ? ST_UPD_IR : ST_PA_IR;
      ST_PA_IR:  state_next = tms_s2_reg ? ST_EX2_IR : ST_PA_IR;
      ST_EX2_IR: state_next = tms_s2_reg ? ST_UPD_IR : ST_SH_IR;
      ST_UPD_IR: state_next = tms_s2_reg ? ST_SEL_DR : ST_IDLE;
      default:   state_next = ST_RESET;
    endcase
  end

  // =====================================================
  // instruction decode
  reg  [`IR_LEN-1:0] ir_shift_reg;
  reg  [`IR_LEN-1:0] ir_reg;

  wire sel_ident  = (ir_reg == `INS_IDENT);
  wire sel_user   = (ir_reg == `INS_USER);
  wire sel_extest = (ir_reg == `INS_EXTEST);
  wire sel_clamp  = (ir_reg == `INS_CLAMP);
  wire sel_highz  = (ir_reg == `INS_HIGHZ);
  wire sel_bsr    = sel_extest | (ir_reg == `INS_SAMPLE);
  // unknown codes fall back to bypass, so a chain never breaks
  wire sel_bypass = ~(sel_ident | sel_user | sel_bsr);

  wire [`ID_LEN-1:0] ident_word;
  assign ident_word[`ID_VER_MSB:`ID_VER_LSB]     = ID_VERSION;
  assign ident_word[`ID_PART_MSB:`ID_PART_LSB]   = ID_PART;
  assign ident_word[`ID_MANUF_MSB:`ID_MANUF_LSB] = ID_MANUF;
  assign ident_word[`ID_MARK_BIT]                = 1'b1;

  // =====================================================
  // boundary chain
  wire       bsr_lsb;
  wire [7:0] upd_out;
  wire [7:0] upd_oe;

  boundary_scan_chain #(
    .LEN  (BSR_LEN),
    .PINS (`PIN_COUNT)
  ) u_chain (
    .clk_sys     (clk_sys),
    .sys_rst     (sys_rst),
    .cap_en      (tck_rise & sel_bsr & (state_reg == ST_CAP_DR)),
    .shift_en    (tck_rise & sel_bsr & (state_reg == ST_SH_DR)),
    .upd_en      (tck_fall & sel_bsr & (state_reg == ST_UPD_DR)),
    .scan_in     (tdi_s2_reg),
    .pin_in      (pad_s2_reg),
    .pin_out     (pad_out_reg),
    .pin_oe      (pad_oe_reg),
    .scan_lsb    (bsr_lsb),
    .upd_out_reg (upd_out),
    .upd_oe_reg  (upd_oe)
  );

  // =====================================================
  // shift registers; tdi taken on rising tck, tdo moves on falling
  reg               bypass_reg;
  reg  [`ID_LEN-1:0] word_reg;

  wire dr_lsb = sel_bsr    ? bsr_lsb :
                sel_bypass ? bypass_reg : word_reg[0];

  always @(posedge clk_sys) begin
    if (sys_rst) begin
      state_reg    <= ST_RESET;
      ir_shift_reg <= `IR_CAPTURE;
      ir_reg       <= `INS_IDENT;
      bypass_reg   <= `BYPASS_CAPTURE;
      word_reg     <= {`ID_LEN{1'b0}};
      tdo_reg      <= 1'b0;
      tdo_oe_reg   <= 1'b0;
    end else if (tck_rise) begin
      state_reg <= state_next;
      if (state_reg == ST_CAP_IR) begin
        ir_shift_reg <= `IR_CAPTURE;
      end else if (state_reg == ST_SH_IR) begin
        ir_shift_reg <= {tdi_s2_reg, ir_shift_reg[`IR_LEN-1:1]};
      end
      if (state_reg == ST_CAP_DR) begin
        bypass_reg <= `BYPASS_CAPTURE;
        word_reg   <= sel_user ? user_code : ident_word;
      end else if (state_reg == ST_SH_DR) begin
        bypass_reg <= tdi_s2_reg;
        word_reg   <= {tdi_s2_reg, word_reg[`ID_LEN-1:1]};
      end
    end else if (tck_fall) begin
      if (state_reg == ST_RESET) begin
        ir_reg <= `INS_IDENT;
      end else if (state_reg == ST_UPD_IR) begin
        ir_reg <= ir_shift_reg;
      end
      if (state_reg == ST_SH_IR) begin
        tdo_reg <= ir_shift_reg[0];
      end else if (state_reg == ST_SH_DR) begin
        tdo_reg <= dr_lsb;
      end
      tdo_oe_reg <= (state_reg == ST_SH_IR) | (state_reg == ST_SH_DR);
    end
  end

  // =====================================================
  // pad drive
  reg [7:0] drv_out;
  reg [7:0] drv_oe;

  always @* begin
    if (sel_extest | sel_clamp) begin
      drv_out = upd_out;
      drv_oe  = upd_oe;
    end else if (sel_highz) begin
      drv_out = core_out;
      drv_oe  = 8'h00;
    end else begin
      drv_out = core_out;
      drv_oe  = core_oe;
    end
  end

  // keepers act whenever the driver is off, whatever the instruction
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      pad_out_reg  <= 8'h00;
      pad_oe_reg   <= 8'h00;
      pad_pull_reg <= 8'h00;
      pad_hold_reg <= 8'h00;
      core_in_reg  <= 8'h00;
    end else begin
      pad_out_reg  <= drv_out;
      pad_oe_reg   <= drv_oe;
      pad_pull_reg <= pull_up_en & ~drv_oe;
      pad_hold_reg <= bus_hold_en & ~pull_up_en & ~drv_oe;
      core_in_reg  <= pad_s2_reg;
    end
  end

endmodule

`default_nettype wire

/* File: verif/jtag_port_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module jtag_port_monitor (
  input wire logic       clk_sys,
  input wire logic       sys_rst,
  input wire logic       tck,
  input wire logic       tdo_reg,
  input wire logic       tdo_oe_reg,
  input wire logic [7:0] pull_up_en,
  input wire logic [7:0] bus_hold_en,
  input wire logic [7:0] pad_oe_reg,
  input wire logic [7:0] pad_pull_reg,
  input wire logic [7:0] pad_hold_reg
);
  // ======
  // port checks
  // first shift after reset is the ir or the identity word, both end in one
  logic seen_reg;
  always @(posedge clk_sys) begin
    seen_reg <= !sys_rst && (seen_reg || tdo_oe_reg);
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  sequence s_tck_low; $past(!tck, 2); endsequence
  sequence s_oe_held; tdo_oe_reg [*7]; endsequence
  sequence s_tdo_held; $stable(tdo_reg) [*6]; endsequence
  AST_TDO_PHASE: assert property ($changed(tdo_reg) |-> s_tck_low)
    else $error("tdo moved while tck high");
  AST_OE_PHASE: assert property ($changed(tdo_oe_reg) |-> s_tck_low)
    else $error("tdo enable moved while tck high");
  AST_OE_HOLD: assert property ($rose(tdo_oe_reg) |-> s_oe_held)
    else $error("tdo enable too short");
  AST_TDO_HOLD: assert property ($changed(tdo_reg) |=> s_tdo_held)
    else $error("tdo bit too short");
  AST_FIRST_ONE: assert property ($rose(tdo_oe_reg) && !seen_reg |-> tdo_reg)
    else $error("first shifted bit not one");
  AST_PULL: assert property (!$past(sys_rst) |-> pad_pull_reg == ($past(pull_up_en) & ~pad_oe_reg))
    else $error("pull-up wrong on released pin");
  AST_HOLD: assert property (!$past(sys_rst) |-> pad_hold_reg == ($past(bus_hold_en & ~pull_up_en) & ~pad_oe_reg))
    else $error("bus hold wrong on released pin");
  AST_RST_QUIET: assert property ($fell(sys_rst) |-> !tdo_oe_reg && pad_oe_reg == 8'h00)
    else $error("outputs driven out of reset");
endmodule
`default_nettype wire

/* File: verif/jtag_ctrl_model.sv */
`timescale 1ns/1ps
`default_nettype none
module jtag_ctrl_model (
  input  wire logic clk_sys,
  input  wire logic tdo,
  output var  logic tck,
  output var  logic tms,
  output var  logic tdi
);
  // ======
  // test controller, tck parked low between frames
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  task automatic step(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    repeat (4) @(negedge clk_sys);
    tck = 1'b1;
    repeat (4) @(negedge clk_sys);
    q = tdo; // late sample: tdo stands until the coming fall
    tck = 1'b0;
  endtask
  // no configuration exists here, so scans never overlap one
  task automatic tap_reset();
    logic q;
    repeat (5) step(1'b1, ~tdi, q);
    step(1'b0, ~tdi, q);
  endtask
  task automatic shift(input logic ir, input int n, input logic [2047:0] din, output logic [2047:0] dout);
    logic q;
    dout = '0;
    step(1'b1, ~tdi, q);
    if (ir) step(1'b1, ~tdi, q);
    repeat (2) step(1'b0, ~tdi, q);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], q);
      dout[i] = q;
    end
    step(1'b1, ~tdi, q);
    step(1'b0, ~tdi, q);
  endtask
endmodule
`default_nettype wire

/* File: verif/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "jtag_map.vh"
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_errors++; $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module tb_top;
  localparam int          LEN = `BSR_LEN_V0;
  localparam logic [31:0] IDW = {4'h3, 16'hA5C3, 11'h2B5, 1'b1}; // arbitrary fields
  logic          clk_sys, sys_rst, tck, tms, tdi, tdo_reg, tdo_oe_reg;
  logic [31:0]   user_code;
  logic [7:0]    core_out, core_oe, core_in_reg, pad_in, pull_up_en, bus_hold_en;
  logic [7:0]    pad_out_reg, pad_oe_reg, pad_pull_reg, pad_hold_reg, upo, upe, eo, oe;
  logic [2047:0] din, dout;
  logic [9:0]    codes [5] = '{`INS_EXTEST, `INS_CLAMP, `INS_HIGHZ, `INS_BYPASS, 10'h2AA};
  int            n_errors = 0, comparisons = 0, seed = 80392;
  jtag_scan_identity_registers #(.VARIANT(0), .ID_VERSION(IDW[31:28]), .ID_PART(IDW[27:12]),
    .ID_MANUF(IDW[11:1])) jtag_scan_identity_registers_inst (.clk_sys, .sys_rst, .tck, .tms, .tdi,
    .tdo_reg, .tdo_oe_reg, .user_code, .core_out, .core_oe, .core_in_reg, .pad_in, .pull_up_en,
    .bus_hold_en, .pad_out_reg, .pad_oe_reg, .pad_pull_reg, .pad_hold_reg);
  jtag_ctrl_model jtag_ctrl_model_inst (.clk_sys, .tdo(tdo_reg), .tck, .tms, .tdi);
  // ======
  // helpers
  task automatic ir(input logic [9:0] c);
    jtag_ctrl_model_inst.shift(1'b1, 10, 2048'(c), dout);
    `CHK(dout[9:0], `IR_CAPTURE);
  endtask
  task automatic dr(input int n);
    for (int i = 0; i < 2048; i++) din[i] = 1'($random(seed));
    jtag_ctrl_model_inst.shift(1'b0, n, din, dout);
  endtask
  // pins: {out, oe} each instruction should present
  function automatic logic [15:0] exp_pads(input logic [9:0] c);
    if (c == `INS_EXTEST || c == `INS_CLAMP) return {upo, upe};
    return {core_out, (c == `INS_HIGHZ) ? 8'h00 : core_oe};
  endfunction
  task automatic end_sim();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  initial begin
    #2_000_000;
    n_errors++;
    end_sim();
  end
  initial begin
    sys_rst = 1'b1;
    user_code = $random(seed);
    {core_out, core_oe, pad_in, pull_up_en} = $random(seed);
    bus_hold_en = 8'h5A;
    repeat (12) @(negedge clk_sys);
    sys_rst = 1'b0;
    repeat (4) @(negedge clk_sys);
    jtag_ctrl_model_inst.tap_reset();
    dr(32);
    `CHK(dout[31:0], IDW);
    ir(`INS_USER);
    dr(32);
    `CHK(dout[31:0], user_code);
    ir(`INS_SAMPLE);
    dr(LEN + 8);
    `CHK(dout[LEN +: 8], din[7:0]);
    for (int p = 0; p < 8; p++) begin
      `CHK(dout[3*p +: 3], {core_oe[p], core_out[p], pad_in[p]});
      // eight extra shifts leave din[k + 8] in cell k
      upo[p] = din[3*p + 9];
      upe[p] = din[3*p + 10];
    end
    // core keeps moving so held pins are told apart from followed ones
    foreach (codes[i]) begin
      {pad_in, pull_up_en, core_out, core_oe} = $random(seed);
      bus_hold_en = 8'($random(seed));
      ir(codes[i]);
      {eo, oe} = exp_pads(codes[i]);
      `CHK(core_in_reg, pad_in);
      `CHK({pad_oe_reg, pad_out_reg & oe}, {oe, eo & oe});
      `CHK({pad_pull_reg, pad_hold_reg}, {pull_up_en & ~oe, bus_hold_en & ~pull_up_en & ~oe});
      if (codes[i] != `INS_EXTEST) begin
        dr(9);
        `CHK(dout[8:0], {din[7:0], `BYPASS_CAPTURE});
        `CHK({pad_oe_reg, pad_out_reg & oe}, {oe, eo & oe});
      end
    end
    ir(`INS_IDENT);
    dr(32);
    `CHK(dout[31:0], IDW);
    // leave a different instruction loaded so the tap reset has work to do
    ir(`INS_USER);
    jtag_ctrl_model_inst.tap_reset();
    dr(32);
    `CHK(dout[31:0], IDW);
    end_sim();
  end
endmodule
bind jtag_scan_identity_registers jtag_port_monitor jtag_port_monitor_inst (.clk_sys, .sys_rst, .tck,
  .tdo_reg, .tdo_oe_reg, .pull_up_en, .bus_hold_en, .pad_oe_reg, .pad_pull_reg, .pad_hold_reg);
`default_nettype wire
